// ===== design/whrs_flow_meter.sv
`timescale 1ns/1ps
module whrs_flow_meter (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Time base, meter pin and total clear.
  input wire logic sec_i,
  input wire logic flow_pulse_i,
  input wire logic total_clear_i,
  // Results.
  output logic [15:0] gpm_o,
  output logic [31:0] gallons_o
);
  import whrs_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    whrs_secs_t win;
    logic [15:0] cnt;
    logic [15:0] gpm;
    logic [31:0] total;
  } whrs_flow_st_t;

  whrs_flow_st_t r_ff;
  whrs_flow_st_t nxt_r;
  logic pulse;

  // One pulse is one gallon, so pulses per minute are gallons per minute.
  always_comb begin
    nxt_r = r_ff;
    nxt_r.s1 = flow_pulse_i;
    nxt_r.s2 = r_ff.s1;
    nxt_r.s3 = r_ff.s2;
    pulse = r_ff.s2 & ~r_ff.s3;
    if (pulse) begin
      nxt_r.cnt = r_ff.cnt + 16'h0001;
    end
    if (sec_i) begin
      if (r_ff.win == FLOW_WINDOW_S - 16'h0001) begin
        nxt_r.win = '0;
        nxt_r.gpm = nxt_r.cnt;
        nxt_r.cnt = '0;
      end else begin
        nxt_r.win = r_ff.win + 16'h0001;
      end
    end
    // A pulse landing on the clear is counted rather than lost.
    if (total_clear_i) begin
      nxt_r.total = '0;
    end
    if (pulse) begin
      nxt_r.total = nxt_r.total + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign gpm_o = r_ff.gpm;
  assign gallons_o = r_ff.total;

  total_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    total_clear_i && !(r_ff.s2 && !r_ff.s3) |=> gallons_o == 32'h0000_0000)
    else $error("gallon total not cleared");

endmodule

// ===== design/whrs_pkg.sv
package whrs_pkg;

  typedef logic [7:0] whrs_temp_t;
  typedef logic [9:0] whrs_press_t;
  typedef logic [15:0] whrs_secs_t;

  typedef enum logic [3:0] {
    ST_STANDBY,
    ST_OIL_RETURN,
    ST_TEMP_CHECK,
    ST_SAMPLE_DELAY,
    ST_HEATING,
    ST_LOW_AMB,
    ST_TEST,
    ST_LOCKOUT,
    ST_AMB_FAULT,
    ST_PURGE
  } whrs_state_t;

  typedef enum logic [2:0] {
    ALM_NONE,
    ALM_SUCTION_LOW,
    ALM_LIQUID_HIGH,
    ALM_SUBCOOL,
    ALM_SUPERHEAT
  } whrs_alarm_t;

  // Clock and the one-second time base.
  localparam int unsigned CLK_HZ = 32'h017d_7840;
  localparam int unsigned TICK_S = 32'h0000_0001;
  localparam int unsigned SEC_CYCLES = CLK_HZ * TICK_S;

  // Sequence times in seconds.
  localparam whrs_secs_t OIL_RETURN_S = 16'h0078;
  localparam whrs_secs_t AMB_VALID_S = 16'h0006;
  localparam whrs_secs_t PURGE_S = 16'h0168;
  localparam int unsigned IDLE_LIMIT_S = 32'h0001_5180;
  localparam whrs_secs_t TEMP_CHECK_S = 16'h003c;
  localparam whrs_secs_t SAMPLE_DELAY_S = 16'h0258;
  localparam whrs_secs_t LIQ_EARLY_S = 16'h003c;
  localparam whrs_secs_t REFRIG_CHECK_S = 16'h010e;
  localparam whrs_secs_t FLOW_WINDOW_S = 16'h003c;

  // Temperatures in whole degrees F.
  localparam whrs_temp_t T_HEAT_MIN = 8'h28;
  localparam whrs_temp_t T_FRZ_ON = 8'h23;
  localparam whrs_temp_t T_FRZ_OFF = 8'h25;
  localparam whrs_temp_t T_OUT_MAX = 8'h89;
  localparam whrs_temp_t T_SUBCOOL_MIN = 8'h04;
  localparam whrs_temp_t T_SUPERHEAT_MAX = 8'h19;
  localparam whrs_temp_t LIM_DEFAULT = 8'h5f;
  localparam whrs_temp_t LIM_BAND1 = 8'h55;
  localparam whrs_temp_t LIM_BAND2 = 8'h5a;
  localparam whrs_temp_t LIM_BAND3 = 8'h5f;
  localparam whrs_temp_t LIM_BAND5 = 8'h64;
  localparam whrs_temp_t OUT_EDGE1 = 8'h69;
  localparam whrs_temp_t OUT_EDGE2 = 8'h6e;
  localparam whrs_temp_t OUT_EDGE3 = 8'h73;
  localparam whrs_temp_t OUT_EDGE4 = 8'h78;

  // Pressures in whole psig.
  localparam whrs_press_t P_SUCTION_MIN = 10'h0a5;
  localparam whrs_press_t P_LIQ_END = 10'h23a;
  localparam whrs_press_t P_LIQ_ALARM = 10'h212;
  localparam whrs_press_t P_LIQ_RECORD = 10'h226;
  localparam whrs_press_t P_WATER_MIN = 10'h005;
  localparam whrs_press_t P_FAN_ON = 10'h190;
  localparam whrs_press_t P_FAN_OFF = 10'h12c;

  // Alarm counting and indicator flashing.
  localparam logic [1:0] LOCK_CNT = 2'h3;
  localparam logic [4:0] FLASH_GAP = 5'h04;

endpackage

// ===== design/whrs_sec_tick.sv
`timescale 1ns/1ps
module whrs_sec_tick #(
  parameter int unsigned SEC_CYCLES = whrs_pkg::SEC_CYCLES
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // One-cycle pulse once per second.
  output logic sec_o
);
  import whrs_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } whrs_tick_st_t;

  whrs_tick_st_t r_ff;
  whrs_tick_st_t nxt_r;

  if (SEC_CYCLES < 2) begin : g_bad
    $error("SEC_CYCLES must be at least 2");
  end

  always_comb begin
    nxt_r = r_ff;
    nxt_r.tick = 1'b0;
    if (r_ff.cnt == 32'(SEC_CYCLES - 1)) begin
      nxt_r.cnt = '0;
      nxt_r.tick = 1'b1;
    end else begin
      nxt_r.cnt = r_ff.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign sec_o = r_ff.tick;

endmodule

// ===== design/whrs_sequencer.sv
`timescale 1ns/1ps
// Summary of operation
// - Stay in standby without a cooling call.
// - Oil return drains the exchanger 120 seconds.
// - First call after standby skips oil return.
// - Test pins: drain only, ignore everything else.
// - Lockout: outputs off, flash code, left on clear or test pins.
// - Bad ambient: pump on until 6 s valid.
// - Bad ambient and suction under 165: lockout.
// - Pump idle 24 hours: run 6 minute purge.
// - Low ambient: cycle outdoor fans for pressure.
// - Pump starts after two minutes if water ok.
// - Sample inlet after 1 minute, else countdown.
// - No water heating below 40 F ambient.
// - Pump on below 35 F until above 37.
// - Liquid line 570 psig ends water heating.
// - Early 530 psig alarms; third locks heating out.
// - Outlet above 137 F ends water heating.
// - Water pressure under 5 psig blocks heating.
// - Subcool under 4 at 270 s: end, alarm.
// - Superheat over 25 at 270 s: end, alarm.
// - Count meter pulses into gpm and total.
// - Clear command zeroes the gallon total.
// - At 550 psig after 1 min, retune inlet limit.
module whrs_sequencer #(
  parameter int unsigned SEC_CYCLES = whrs_pkg::SEC_CYCLES,
  parameter int unsigned IDLE_LIMIT_S = whrs_pkg::IDLE_LIMIT_S,
  parameter whrs_pkg::whrs_temp_t LIM_BAND4 = whrs_pkg::LIM_DEFAULT
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Host commands.
  input wire logic cool_call_i,
  input wire logic alarm_clear_i,
  input wire logic total_clear_i,
  // Pins.
  input wire logic test_pins_i,
  input wire logic flow_pulse_i,
  // Sensor readings.
  input wire logic amb_valid_i,
  input wire whrs_pkg::whrs_temp_t amb_temp_i,
  input wire whrs_pkg::whrs_temp_t inlet_temp_i,
  input wire whrs_pkg::whrs_temp_t outlet_temp_i,
  input wire whrs_pkg::whrs_temp_t subcool_value_i,
  input wire whrs_pkg::whrs_temp_t superheat_value_i,
  input wire whrs_pkg::whrs_press_t liquid_line_pressure_i,
  input wire whrs_pkg::whrs_press_t suction_pressure_i,
  input wire whrs_pkg::whrs_press_t water_supply_pressure_i,
  // Actuators.
  output logic pump_o,
  output logic drain_o,
  output logic fan_o,
  output logic heat_o,
  output logic led_o,
  // Status to the host.
  output whrs_pkg::whrs_state_t state_o,
  output whrs_pkg::whrs_secs_t timer_o,
  output whrs_pkg::whrs_temp_t inlet_limit_o,
  output logic alarm_stb_o,
  output whrs_pkg::whrs_alarm_t alarm_code_o,
  output logic [15:0] gpm_o,
  output logic [31:0] gallons_o
);
  import whrs_pkg::*;

  if (IDLE_LIMIT_S < 1 || IDLE_LIMIT_S > 32'h0001_ffff) begin : g_bad
    $error("IDLE_LIMIT_S out of range");
  end

  typedef struct packed {
    whrs_state_t state;
    whrs_secs_t tmr;
    logic [16:0] idle;
    logic test_s1;
    logic test_s2;
    logic frz;
    logic [1:0] liq_cnt;
    logic [1:0] sc_cnt;
    logic [1:0] sh_cnt;
    logic liq_lock;
    logic ref_lock;
    logic liq_alarmed;
    logic recorded;
    whrs_temp_t limit;
    logic pump;
    logic drain;
    logic fan;
    logic heat;
    logic led;
    logic [4:0] flash;
    whrs_secs_t timer;
    logic alarm_stb;
    whrs_alarm_t alarm_code;
  } whrs_seq_st_t;

  whrs_seq_st_t r_ff;
  whrs_seq_st_t nxt_r;
  logic sec;

  ////////////////////////////////////////////////////////////////////////////

  whrs_sec_tick #(.SEC_CYCLES(SEC_CYCLES)) u_tick (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .sec_o(sec)
  );

  whrs_flow_meter u_flow (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .sec_i(sec),
    .flow_pulse_i(flow_pulse_i),
    .total_clear_i(total_clear_i),
    .gpm_o(gpm_o),
    .gallons_o(gallons_o)
  );

  ////////////////////////////////////////////////////////////////////////////

  function automatic whrs_temp_t lim_of(input whrs_temp_t t);
    if (t < OUT_EDGE1) begin
      return LIM_BAND1;
    end else if (t < OUT_EDGE2) begin
      return LIM_BAND2;
    end else if (t < OUT_EDGE3) begin
      return LIM_BAND3;
    end else if (t <= OUT_EDGE4) begin
      return LIM_BAND4;
    end else begin
      return LIM_BAND5;
    end
  endfunction

  logic water_ok;
  logic amb_warm;
  logic entry_ok;
  assign water_ok = water_supply_pressure_i >= P_WATER_MIN;
  assign amb_warm = amb_temp_i >= T_HEAT_MIN;
  assign entry_ok = water_ok && amb_warm && !r_ff.liq_lock && !r_ff.ref_lock;

  always_comb begin
    whrs_state_t nst;
    whrs_alarm_t alm;
    logic ac_state;
    nst = r_ff.state;
    alm = ALM_NONE;
    ac_state = 1'b0;
    nxt_r = r_ff;
    nxt_r.test_s1 = test_pins_i;
    nxt_r.test_s2 = r_ff.test_s1;
    nxt_r.alarm_stb = 1'b0;
    if (sec && r_ff.tmr != 16'hffff) begin
      nxt_r.tmr = r_ff.tmr + 16'h0001;
    end
    // The freeze guard keeps its own hysteresis even in test and lockout.
    if (amb_temp_i < T_FRZ_ON) begin
      nxt_r.frz = 1'b1;
    end else if (amb_temp_i > T_FRZ_OFF) begin
      nxt_r.frz = 1'b0;
    end
    if (alarm_clear_i) begin
      nxt_r.liq_lock = 1'b0;
      nxt_r.liq_cnt = '0;
      nxt_r.alarm_code = ALM_NONE;
    end
    if (r_ff.test_s2) begin
      nst = ST_TEST;
    end else if (r_ff.state == ST_TEST) begin
      nst = ST_STANDBY;
    end else if (r_ff.state == ST_LOCKOUT) begin
      if (alarm_clear_i) begin
        nst = ST_STANDBY;
      end
    end else if (!cool_call_i) begin
      nst = ST_STANDBY;
      if (r_ff.state == ST_PURGE && r_ff.tmr < PURGE_S) begin
        nst = ST_PURGE;
      end else if (r_ff.state == ST_STANDBY && r_ff.idle >= 17'(IDLE_LIMIT_S)) begin
        nst = ST_PURGE;
      end
      nxt_r.liq_cnt = '0;
      nxt_r.sc_cnt = '0;
      nxt_r.sh_cnt = '0;
    end else if (!amb_valid_i) begin
      nst = ST_AMB_FAULT;
      nxt_r.tmr = '0;
      if (suction_pressure_i < P_SUCTION_MIN) begin
        nst = ST_LOCKOUT;
        alm = ALM_SUCTION_LOW;
      end
    end else if (!amb_warm && (r_ff.state == ST_OIL_RETURN || r_ff.state == ST_SAMPLE_DELAY
        || r_ff.state == ST_TEMP_CHECK || r_ff.state == ST_HEATING)) begin
      nst = ST_LOW_AMB;
    end else begin
      case (r_ff.state)
        ST_STANDBY, ST_PURGE: begin
          nst = entry_ok ? ST_TEMP_CHECK : ST_SAMPLE_DELAY;
        end
        ST_AMB_FAULT: begin
          if (r_ff.tmr >= AMB_VALID_S) begin
            nst = ST_OIL_RETURN;
          end
        end
        ST_OIL_RETURN: begin
          if (r_ff.tmr >= OIL_RETURN_S) begin
            nst = entry_ok ? ST_TEMP_CHECK : ST_SAMPLE_DELAY;
          end
        end
        ST_SAMPLE_DELAY: begin
          if (r_ff.tmr >= SAMPLE_DELAY_S) begin
            nst = entry_ok ? ST_TEMP_CHECK : ST_SAMPLE_DELAY;
            nxt_r.tmr = '0;
          end
        end
        ST_LOW_AMB: begin
          nst = ST_SAMPLE_DELAY;
          if (!amb_warm) begin
            nst = ST_LOW_AMB;
          end
        end
        ST_TEMP_CHECK: begin
          if (r_ff.tmr >= TEMP_CHECK_S) begin
            nst = (entry_ok && inlet_temp_i < r_ff.limit) ? ST_HEATING : ST_SAMPLE_DELAY;
          end
        end
        ST_HEATING: begin
          if (outlet_temp_i > T_OUT_MAX || liquid_line_pressure_i >= P_LIQ_END) begin
            nst = ST_SAMPLE_DELAY;
          end
          if (r_ff.tmr < LIQ_EARLY_S && liquid_line_pressure_i > P_LIQ_ALARM
              && !r_ff.liq_alarmed) begin
            alm = ALM_LIQUID_HIGH;
            nxt_r.liq_alarmed = 1'b1;
            nxt_r.liq_cnt = r_ff.liq_cnt + 2'h1;
            if (r_ff.liq_cnt == LOCK_CNT - 2'h1) begin
              nxt_r.liq_lock = 1'b1;
              nst = ST_SAMPLE_DELAY;
            end
          end
          if (r_ff.tmr >= LIQ_EARLY_S && liquid_line_pressure_i >= P_LIQ_RECORD
              && !r_ff.recorded) begin
            nxt_r.recorded = 1'b1;
            nxt_r.limit = lim_of(outlet_temp_i);
          end
          if (r_ff.tmr == REFRIG_CHECK_S) begin
            if (subcool_value_i < T_SUBCOOL_MIN) begin
              nst = ST_SAMPLE_DELAY;
              alm = ALM_SUBCOOL;
              nxt_r.sc_cnt = r_ff.sc_cnt + 2'h1;
              if (r_ff.sc_cnt == LOCK_CNT - 2'h1) begin
                nxt_r.ref_lock = 1'b1;
              end
            end
            if (superheat_value_i > T_SUPERHEAT_MAX) begin
              nst = ST_SAMPLE_DELAY;
              alm = ALM_SUPERHEAT;
              nxt_r.sh_cnt = r_ff.sh_cnt + 2'h1;
              if (r_ff.sh_cnt == LOCK_CNT - 2'h1) begin
                nxt_r.ref_lock = 1'b1;
              end
            end
          end
        end
        default: begin
          nst = ST_STANDBY;
        end
      endcase
    end
    if (nst != r_ff.state) begin
      nxt_r.tmr = '0;
    end
    if (nst == ST_HEATING && r_ff.state != ST_HEATING) begin
      nxt_r.liq_alarmed = 1'b0;
      nxt_r.recorded = 1'b0;
    end
    if (alm != ALM_NONE) begin
      nxt_r.alarm_stb = 1'b1;
      nxt_r.alarm_code = alm;
    end
    nxt_r.state = nst;
    ac_state = nst == ST_OIL_RETURN || nst == ST_TEMP_CHECK || nst == ST_SAMPLE_DELAY
        || nst == ST_HEATING || nst == ST_AMB_FAULT;
    // Outputs follow the next state so they change with it on one edge.
    nxt_r.pump = nst == ST_TEMP_CHECK || nst == ST_HEATING || nst == ST_AMB_FAULT
        || nst == ST_PURGE || (nxt_r.frz && nst != ST_TEST && nst != ST_LOCKOUT);
    nxt_r.drain = nst == ST_OIL_RETURN || nst == ST_TEST;
    nxt_r.heat = nst == ST_HEATING;
    if (nst == ST_LOW_AMB) begin
      if (liquid_line_pressure_i > P_FAN_ON) begin
        nxt_r.fan = 1'b1;
      end else if (liquid_line_pressure_i < P_FAN_OFF) begin
        nxt_r.fan = 1'b0;
      end
    end else begin
      nxt_r.fan = ac_state;
    end
    if (nxt_r.pump) begin
      nxt_r.idle = '0;
    end else if (sec && r_ff.idle != 17'h1ffff) begin
      nxt_r.idle = r_ff.idle + 17'h00001;
    end
    nxt_r.timer = (nst == ST_SAMPLE_DELAY) ? SAMPLE_DELAY_S - nxt_r.tmr : '0;
    // Code n shows as n blinks, then a dark gap, repeating.
    if (nst != ST_LOCKOUT) begin
      nxt_r.flash = '0;
    end else if (sec) begin
      if (r_ff.flash >= {1'b0, r_ff.alarm_code, 1'b0} + FLASH_GAP - 5'h01) begin
        nxt_r.flash = '0;
      end else begin
        nxt_r.flash = r_ff.flash + 5'h01;
      end
    end
    nxt_r.led = nst == ST_LOCKOUT && nxt_r.flash < {1'b0, nxt_r.alarm_code, 1'b0}
        && !nxt_r.flash[0];
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_ff <= '0;
      r_ff.state <= ST_STANDBY;
      r_ff.limit <= LIM_DEFAULT;
      r_ff.alarm_code <= ALM_NONE;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign pump_o = r_ff.pump;
  assign drain_o = r_ff.drain;
  assign fan_o = r_ff.fan;
  assign heat_o = r_ff.heat;
  assign led_o = r_ff.led;
  assign state_o = r_ff.state;
  assign timer_o = r_ff.timer;
  assign inlet_limit_o = r_ff.limit;
  assign alarm_stb_o = r_ff.alarm_stb;
  assign alarm_code_o = r_ff.alarm_code;

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  standby_hold_a: assert property (
    !cool_call_i && !r_ff.test_s2 && state_o != ST_LOCKOUT && state_o != ST_TEST
    |=> state_o == ST_STANDBY || state_o == ST_PURGE) else $error("left standby");
  oil_drain_a: assert property (
    state_o == ST_OIL_RETURN |-> drain_o && !heat_o) else $error("oil return not draining");
  first_call_a: assert property (
    state_o == ST_STANDBY && cool_call_i && amb_valid_i && entry_ok && !r_ff.test_s2
    |=> state_o == ST_TEMP_CHECK && pump_o) else $error("first call did not check");
  test_outputs_a: assert property (
    state_o == ST_TEST |-> drain_o && !pump_o && !fan_o && !heat_o)
    else $error("test override outputs wrong");
  lockout_out_a: assert property (
    state_o == ST_LOCKOUT |-> !pump_o && !drain_o && !fan_o && !heat_o)
    else $error("lockout outputs on");
  suction_lock_a: assert property (
    cool_call_i && !amb_valid_i && suction_pressure_i < P_SUCTION_MIN && !r_ff.test_s2
    && state_o != ST_TEST |=> state_o == ST_LOCKOUT ##1 alarm_code_o == ALM_SUCTION_LOW)
    else $error("suction fault missed");
  heat_entry_a: assert property (
    $rose(heat_o) |-> $past(amb_temp_i) >= T_HEAT_MIN
    && $past(water_supply_pressure_i) >= P_WATER_MIN) else $error("bad heating entry");
  outlet_end_a: assert property (
    state_o == ST_HEATING && cool_call_i && amb_valid_i && outlet_temp_i > T_OUT_MAX
    |=> !heat_o) else $error("outlet limit ignored");
  freeze_pump_a: assert property (
    amb_temp_i < T_FRZ_ON && !r_ff.test_s2 && state_o != ST_LOCKOUT && state_o != ST_TEST
    && cool_call_i |=> pump_o || state_o == ST_LOCKOUT) else $error("freeze pump off");

  heating_c: cover property ($rose(heat_o));
  lockout_c: cover property (state_o == ST_LOCKOUT ##1 alarm_clear_i);
  purge_c: cover property (state_o == ST_PURGE && pump_o);
  delay_c: cover property (state_o == ST_SAMPLE_DELAY ##1 state_o == ST_TEMP_CHECK);

endmodule

// ===== verif/whrs_meter_model.sv
`timescale 1ns/1ps
// Pulse-type water meter: one contact closure for every gallon that passes.
module whrs_meter_model (
  // Clock.
  input wire logic ref_clk_i,
  // Meter contact.
  output logic flow_pulse_o
);
  initial flow_pulse_o = 1'b0;
  // Closures last three cycles so that the three-flop input stage always catches them.
  task automatic send(input int gallons);
    repeat (gallons) begin
      @(negedge ref_clk_i);
      flow_pulse_o = 1'b1;
      repeat (3) @(negedge ref_clk_i);
      flow_pulse_o = 1'b0;
      repeat (3) @(negedge ref_clk_i);
    end
  endtask
endmodule

// ===== verif/whrs_sequencer_tb_top.sv
`timescale 1ns/1ps
module whrs_sequencer_tb_top;
  import whrs_pkg::*;
  // One second is shortened to ten clocks so the long timers fit in the run.
  localparam int unsigned SEC = 10;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cool_call_i = 1'b0;
  logic alarm_clear_i = 1'b0;
  logic total_clear_i = 1'b0;
  logic test_pins_i = 1'b0;
  logic amb_valid_i = 1'b1;
  logic flow_pulse_i;
  whrs_temp_t amb_temp_i = 8'h46;
  whrs_temp_t inlet_temp_i = 8'h50;
  whrs_temp_t outlet_temp_i = 8'h64;
  whrs_temp_t subcool_value_i = 8'h0a;
  whrs_temp_t superheat_value_i = 8'h0a;
  whrs_press_t liquid_line_pressure_i = 10'h15e;
  whrs_press_t suction_pressure_i = 10'h0c8;
  whrs_press_t water_supply_pressure_i = 10'h014;
  logic pump_o, drain_o, fan_o, heat_o, led_o, alarm_stb_o;
  whrs_state_t state_o;
  whrs_secs_t timer_o;
  whrs_temp_t inlet_limit_o;
  whrs_alarm_t alarm_code_o;
  logic [15:0] gpm_o;
  logic [31:0] gallons_o;
  int num_errors = 0;
  int tests_run = 0;

  whrs_sequencer #(.SEC_CYCLES(SEC), .IDLE_LIMIT_S(20), .LIM_BAND4(8'h5d)) i_whrs_sequencer (
    .ref_clk_i, .rst_i, .cool_call_i, .alarm_clear_i, .total_clear_i, .test_pins_i,
    .flow_pulse_i, .amb_valid_i, .amb_temp_i, .inlet_temp_i, .outlet_temp_i,
    .subcool_value_i, .superheat_value_i, .liquid_line_pressure_i, .suction_pressure_i,
    .water_supply_pressure_i, .pump_o, .drain_o, .fan_o, .heat_o, .led_o, .state_o,
    .timer_o, .inlet_limit_o, .alarm_stb_o, .alarm_code_o, .gpm_o, .gallons_o);
  whrs_meter_model i_whrs_meter_model (.ref_clk_i, .flow_pulse_o(flow_pulse_i));

  always #20 ref_clk_i = ~ref_clk_i;

  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (num_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("Error %s expected %0h seen %0h", what, exp, got);
      num_errors++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  // A state that never arrives ends the run, since later steps assume it.
  task automatic wait_st(input whrs_state_t s, input int n);
    for (int i = 0; i < n && state_o !== s; i++) cyc(1);
    chk("state", s, state_o);
    if (state_o !== s) report_and_stop();
  endtask
  task automatic pulse_clear();
    alarm_clear_i = 1'b1;
    cyc(1);
    alarm_clear_i = 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic t_purge();
    chk("state", ST_STANDBY, state_o);
    chk("pump", 0, pump_o);
    wait_st(ST_PURGE, 30 * SEC);
    chk("pump", 1, pump_o);
    cyc(355 * SEC);
    chk("state", ST_PURGE, state_o);
    wait_st(ST_STANDBY, 10 * SEC);
    chk("pump", 0, pump_o);
  endtask
  task automatic t_flow();
    int i;
    total_clear_i = 1'b1;
    cyc(1);
    total_clear_i = 1'b0;
    i_whrs_meter_model.send(5);
    cyc(4);
    chk("gallons", 5, gallons_o);
    for (i = 0; i < 130 * SEC && gpm_o === 16'h0000; i++) cyc(1);
    chk("gpm window", 1, i < 130 * SEC);
    for (i = 0; i < 130 * SEC && gpm_o !== 16'h0000; i++) cyc(1);
    chk("gpm window", 1, i < 130 * SEC);
    i_whrs_meter_model.send(7);
    for (i = 0; i < 65 * SEC && gpm_o !== 16'h0007; i++) cyc(1);
    chk("gpm", 7, gpm_o);
    chk("gallons", 12, gallons_o);
    total_clear_i = 1'b1;
    cyc(1);
    total_clear_i = 1'b0;
    cyc(1);
    chk("gallons", 0, gallons_o);
  endtask
  task automatic t_heat();
    whrs_temp_t outl[5] = '{8'h64, 8'h6b, 8'h70, 8'h75, 8'h7d};
    whrs_temp_t lim[5] = '{8'h55, 8'h5a, 8'h5f, 8'h5d, 8'h64};
    cool_call_i = 1'b1;
    cyc(2);
    chk("state", ST_TEMP_CHECK, state_o);
    chk("pump", 1, pump_o);
    cyc(58 * SEC);
    chk("state", ST_TEMP_CHECK, state_o);
    for (int k = 0; k < 5; k++) begin
      wait_st(ST_HEATING, 670 * SEC);
      chk("heat", 1, heat_o);
      cyc(62 * SEC);
      liquid_line_pressure_i = 10'h226;
      outlet_temp_i = outl[k];
      cyc(3);
      chk("limit", lim[k], inlet_limit_o);
      outlet_temp_i = 8'h8a;
      cyc(3);
      chk("state", ST_SAMPLE_DELAY, state_o);
      chk("timer", 1, timer_o > 16'h0255);
      liquid_line_pressure_i = 10'h15e;
      outlet_temp_i = 8'h64;
    end
  endtask
  task automatic t_liq();
    int i;
    for (int k = 0; k < 3; k++) begin
      wait_st(ST_HEATING, 670 * SEC);
      liquid_line_pressure_i = 10'h23a;
      for (i = 0; i < 4 && alarm_stb_o !== 1'b1; i++) cyc(1);
      chk("alarm", 1, alarm_stb_o);
      chk("code", ALM_LIQUID_HIGH, alarm_code_o);
      cyc(3);
      chk("state", ST_SAMPLE_DELAY, state_o);
      liquid_line_pressure_i = 10'h15e;
    end
    for (i = 0; i < 670 * SEC && heat_o === 1'b0; i++) cyc(1);
    chk("heat", 0, heat_o);
    pulse_clear();
    cyc(2);
    chk("code", ALM_NONE, alarm_code_o);
    wait_st(ST_HEATING, 670 * SEC);
  endtask
  // Entered while heating has just begun, so the refrigerant check lands near 270 s.
  task automatic t_ref();
    int i;
    subcool_value_i = 8'h03;
    for (i = 0; i < 290 * SEC && alarm_stb_o !== 1'b1; i++) cyc(1);
    chk("alarm", 1, alarm_stb_o);
    chk("code", ALM_SUBCOOL, alarm_code_o);
    cyc(2);
    chk("state", ST_SAMPLE_DELAY, state_o);
    chk("heat", 0, heat_o);
    subcool_value_i = 8'h0a;
  endtask
  task automatic t_low();
    amb_temp_i = 8'h26;
    cyc(3);
    chk("state", ST_LOW_AMB, state_o);
    chk("heat", 0, heat_o);
    liquid_line_pressure_i = 10'h1c2;
    cyc(3);
    chk("fan", 1, fan_o);
    liquid_line_pressure_i = 10'h0fa;
    cyc(3);
    chk("fan", 0, fan_o);
    amb_temp_i = 8'h22;
    cyc(3);
    chk("pump", 1, pump_o);
    amb_temp_i = 8'h25;
    cyc(3);
    chk("pump", 1, pump_o);
    amb_temp_i = 8'h46;
    liquid_line_pressure_i = 10'h15e;
  endtask
  task automatic t_water();
    int i;
    cool_call_i = 1'b0;
    cyc(2);
    chk("state", ST_STANDBY, state_o);
    water_supply_pressure_i = 10'h003;
    cool_call_i = 1'b1;
    for (i = 0; i < 70 * SEC && heat_o === 1'b0; i++) cyc(1);
    chk("heat", 0, heat_o);
    chk("state", ST_SAMPLE_DELAY, state_o);
    water_supply_pressure_i = 10'h014;
    cool_call_i = 1'b0;
    cyc(2);
  endtask
  task automatic t_amb();
    cool_call_i = 1'b1;
    amb_valid_i = 1'b0;
    cyc(3);
    chk("state", ST_AMB_FAULT, state_o);
    chk("pump", 1, pump_o);
    amb_valid_i = 1'b1;
    cyc(4 * SEC);
    amb_valid_i = 1'b0;
    cyc(2);
    amb_valid_i = 1'b1;
    cyc(4 * SEC);
    chk("state", ST_AMB_FAULT, state_o);
    wait_st(ST_OIL_RETURN, 3 * SEC);
    chk("drain", 1, drain_o);
    cyc(118 * SEC);
    chk("drain", 1, drain_o);
    wait_st(ST_TEMP_CHECK, 3 * SEC);
    amb_valid_i = 1'b0;
    suction_pressure_i = 10'h0a4;
    cyc(4);
    chk("state", ST_LOCKOUT, state_o);
    chk("code", ALM_SUCTION_LOW, alarm_code_o);
    chk("outputs", 0, {pump_o, drain_o, fan_o, heat_o});
    for (int i = 0; i < 8 * SEC && led_o !== 1'b1; i++) cyc(1);
    chk("led", 1, led_o);
    amb_valid_i = 1'b1;
    suction_pressure_i = 10'h0c8;
    cool_call_i = 1'b0;
    cyc(3);
    chk("state", ST_LOCKOUT, state_o);
    pulse_clear();
    cyc(3);
    chk("state", ST_STANDBY, state_o);
  endtask
  task automatic t_test();
    cool_call_i = 1'b1;
    test_pins_i = 1'b1;
    cyc(4);
    chk("state", ST_TEST, state_o);
    chk("outputs", 4'h4, {pump_o, drain_o, fan_o, heat_o});
    amb_valid_i = 1'b0;
    cool_call_i = 1'b0;
    cyc(3);
    chk("state", ST_TEST, state_o);
    chk("outputs", 4'h4, {pump_o, drain_o, fan_o, heat_o});
    test_pins_i = 1'b0;
    amb_valid_i = 1'b1;
    cyc(5);
  endtask

  //////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(16);
    rst_i = 1'b0;
    t_purge();
    t_flow();
    t_heat();
    t_liq();
    t_ref();
    t_low();
    t_water();
    t_amb();
    t_test();
    report_and_stop();
  end
endmodule
